// ---- common/cdr_ctl_regs.svh ----
// Register offsets, field positions and timing counts for the decoder control bank.
// Assumes a 100 MHz system clock and a 4-bit register address.
`ifndef CDR_CTL_REGS_SVH
`define CDR_CTL_REGS_SVH
`define CDR_A_MASK    4'h0
`define CDR_A_CLR     4'h1
`define CDR_A_CHIP    4'h2
`define CDR_A_HIF     4'h3
`define CDR_A_PAGE    4'h4
`define CDR_A_DLA_L   4'h5
`define CDR_A_DLA_H   4'h6
`define CDR_A_DAC_L   4'h7
`define CDR_A_DAC_H   4'h8
`define CDR_A_HAC_L   4'h9
`define CDR_A_HAC_H   4'ha
`define CDR_A_HXC_L   4'hb
`define CDR_A_HXC_H   4'hc
`define CDR_A_XFER    4'hd
`define CDR_A_DEC     4'he
`define CDR_A_RSLT    4'hf
`define CDR_A_STS     4'h0
`define CDR_A_HOST_INTERFACE_STATE  4'h1
`define CDR_CHIP_RST  1
`define CDR_CHIP_SWO  2
`define CDR_CHIP_RPG  3
`define CDR_HIF_CLRR  6
`define CDR_HIF_CLRB  7
`define CDR_XF_HDMA   1
`define CDR_XF_XTC    2
`define CDR_XF_CCE    3
`define CDR_DEC_STOP  7
`define CDR_ST_DEC    0
`define CDR_ST_HCMP   1
`define CDR_ST_OVR    2
`define CDR_ST_CMD    3
`define CDR_ST_HRST   4
`define CDR_ST_RSE    5
`define CDR_ST_TOUT   6
`define CDR_SECTOR_BYTES 12'd2352
`define CDR_CLK_MHZ   100
`define CDR_TOUT_US   40600
`define CDR_TOUT_CYC  (`CDR_TOUT_US * `CDR_CLK_MHZ)
`define CDR_INIT_CYC  3'd4
`define CDR_RSLT_DEPTH 10
`endif

// ---- common/cdr_pkg.sv ----
// Types shared by the decoder control bank.
// Assumes the register header is included where offsets are needed.
package cdr_pkg;
  typedef enum logic [2:0] {
    CDR_IDLE, CDR_MONITOR, CDR_WRITE_ONLY, CDR_REALTIME, CDR_REPEAT, CDR_AUDIO
  } cdr_mode_e;
  typedef struct packed {
    logic       cmd_wr;
    logic       chip_reset;
    logic       result_rd;
    logic [2:0] clr_int;
  } cdr_host_ev_s;
  typedef struct packed {
    logic sync_detect;
    logic sync_insert;
    logic corr_done;
    logic byte_wr;
  } cdr_drive_ev_s;
endpackage

// ---- design/cdr_ctl.sv ----
// Decoder control register bank: interrupts, buffer counters, chip and host control.
// Assumes one 100 MHz clock and a synchronous register port with one-cycle strobes.
`timescale 1ns/1ns
`include "cdr_ctl_regs.svh"
module cdr_ctl #(
  parameter int TOUT_CYC = `CDR_TOUT_CYC,
  parameter int DEPTH    = `CDR_RSLT_DEPTH
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [3:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [7:0]            reg_rdata,
  input  wire cdr_pkg::cdr_drive_ev_s drive_ev,
  input  wire logic                  cpu_dma_byte,
  input  wire logic                  host_dma_xfer,
  input  wire logic                  external_terminal_count,
  input  wire cdr_pkg::cdr_host_ev_s host_ev,
  output logic                       irq,
  output logic      [15:0]           buffer_address_bus,
  output logic                       buffer_write_strobe,
  output logic                       drive_write_blocked,
  output logic                       host_dma_active,
  output logic                       sync_window_open,
  output logic                       repeat_correction_go,
  output logic                       init_busy,
  output logic      [2:0]            host_interrupt_state,
  output logic                       host_busy_flag,
  output logic      [7:0]            result_data,
  output logic                       result_fifo_empty
);
  localparam int PW = $clog2(DEPTH);
  logic [6:0]  mask_reg, sts_reg, sts_set;
  logic [7:0]  chip_reg, xfer_reg, dec_reg, page_reg;
  logic [15:0] dla_reg, dac_reg, hac_reg, hxc_reg;
  logic [2:0]  init_cnt;
  logic        init_host;
  logic [11:0] gap_cnt;
  logic [22:0] tout_cnt;
  cdr_pkg::cdr_mode_e mode, mode_q;
  logic [7:0]  fifo [DEPTH];
  logic [PW-1:0] wp, rp;
  logic [PW:0] cnt;
  logic        wr_hit;
  logic        sync_ev, short_gap, tout_mode, stop_mode;
  logic        drv_ok, hx_tc, xtc_end, rd_ok;

  function automatic logic hit(input logic [3:0] a);
    hit = reg_wr && reg_addr == a;
  endfunction

  assign mode = cdr_pkg::cdr_mode_e'(dec_reg[2:0]);
  assign init_busy = init_cnt != 3'd0;
  assign sync_window_open = chip_reg[`CDR_CHIP_SWO];
  assign host_dma_active = xfer_reg[`CDR_XF_HDMA];
  assign tout_mode = mode inside {cdr_pkg::CDR_MONITOR, cdr_pkg::CDR_WRITE_ONLY, cdr_pkg::CDR_REALTIME};
  assign stop_mode = mode inside {cdr_pkg::CDR_WRITE_ONLY, cdr_pkg::CDR_REALTIME, cdr_pkg::CDR_AUDIO};
  assign sync_ev = drive_ev.sync_detect | drive_ev.sync_insert;
  assign short_gap = sync_window_open && gap_cnt < `CDR_SECTOR_BYTES;
  assign drv_ok = drive_ev.byte_wr && !drive_write_blocked && !init_busy;
  assign hx_tc = host_dma_xfer && host_dma_active && xfer_reg[`CDR_XF_CCE] && hxc_reg == 16'h0001;
  assign xtc_end = external_terminal_count && host_dma_active && xfer_reg[`CDR_XF_XTC];
  assign rd_ok = host_ev.result_rd && cnt != '0;
  assign result_fifo_empty = cnt == '0;
  assign wr_hit = reg_wr && reg_addr == `CDR_A_RSLT && cnt != (PW+1)'(DEPTH);

  // Soft or host reset sequence
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_cnt  <= 3'd0;
      init_host <= 1'b0;
    end else if (host_ev.chip_reset) begin
      init_cnt  <= `CDR_INIT_CYC;
      init_host <= 1'b1;
    end else if (hit(`CDR_A_CHIP) && reg_wdata[`CDR_CHIP_RST] && !init_busy) begin
      init_cnt  <= `CDR_INIT_CYC;
      init_host <= 1'b0;
    end else if (init_busy) begin
      init_cnt <= init_cnt - 3'd1;
    end
  end

  // Status set terms, independent of mask
  always_comb begin
    sts_set = '0;
    sts_set[`CDR_ST_DEC] = (sync_ev && tout_mode && !short_gap)
                         || (drive_ev.corr_done && mode == cdr_pkg::CDR_REPEAT);
    sts_set[`CDR_ST_HCMP] = hx_tc || xtc_end;
    sts_set[`CDR_ST_OVR] = drv_ok && dac_reg == dla_reg
                         && ((stop_mode && dec_reg[`CDR_DEC_STOP]) || mode == cdr_pkg::CDR_AUDIO);
    sts_set[`CDR_ST_CMD] = host_ev.cmd_wr;
    sts_set[`CDR_ST_HRST] = init_cnt == 3'd1 && init_host;
    sts_set[`CDR_ST_RSE] = rd_ok && cnt == (PW+1)'(1) && !wr_hit;
    sts_set[`CDR_ST_TOUT] = tout_mode && tout_cnt == 23'd1 && !sync_ev;
  end

  // Interrupt status; set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sts_reg <= '0;
    end else begin
      sts_reg <= ((init_busy ? 7'h00 : sts_reg)
                 & ~(hit(`CDR_A_CLR) ? reg_wdata[6:0] : 7'h00)) | sts_set;
    end
  end

  assign irq = |(sts_reg & mask_reg);

  // Plain control registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg <= '0;
      page_reg <= '0;
      dec_reg  <= '0;
      dla_reg  <= '0;
      chip_reg <= '0;
    end else begin
      if (hit(`CDR_A_MASK))
        mask_reg <= reg_wdata[6:0];
      if (hit(`CDR_A_PAGE))
        page_reg <= reg_wdata & 8'h80;
      if (init_busy)
        dec_reg <= '0;
      else if (hit(`CDR_A_DEC))
        dec_reg <= reg_wdata;
      if (hit(`CDR_A_DLA_L))
        dla_reg[7:0] <= reg_wdata;
      if (hit(`CDR_A_DLA_H))
        dla_reg[15:8] <= reg_wdata;
      if (init_busy) begin
        chip_reg <= '0;
      end else if (hit(`CDR_A_CHIP)) begin
        chip_reg <= reg_wdata & 8'h0d;
      end else if (mode == cdr_pkg::CDR_REPEAT) begin
        chip_reg[`CDR_CHIP_RPG] <= 1'b0;
      end
    end
  end

  assign repeat_correction_go = chip_reg[`CDR_CHIP_RPG] && mode == cdr_pkg::CDR_REPEAT;

  // Drive write counter and stop-at-last-address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dac_reg <= '0;
      drive_write_blocked <= 1'b0;
    end else if (init_busy) begin
      dac_reg <= '0;
      drive_write_blocked <= 1'b0;
    end else begin
      if (hit(`CDR_A_DAC_L))
        dac_reg[7:0] <= reg_wdata;
      else if (hit(`CDR_A_DAC_H))
        dac_reg[15:8] <= reg_wdata;
      else if (drv_ok || cpu_dma_byte)
        dac_reg <= dac_reg + 16'h0001;
      if (hit(`CDR_A_DEC))
        drive_write_blocked <= 1'b0;
      else if (drv_ok && dac_reg == dla_reg && stop_mode && dec_reg[`CDR_DEC_STOP])
        drive_write_blocked <= 1'b1;
    end
  end

  // Host DMA counters and enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hac_reg  <= '0;
      hxc_reg  <= '0;
      xfer_reg <= '0;
    end else if (init_busy) begin
      hac_reg  <= '0;
      hxc_reg  <= '0;
      xfer_reg <= '0;
    end else begin
      if (hit(`CDR_A_HAC_L))
        hac_reg[7:0] <= reg_wdata;
      else if (hit(`CDR_A_HAC_H))
        hac_reg[15:8] <= reg_wdata;
      else if (host_dma_xfer && host_dma_active)
        hac_reg <= hac_reg + 16'h0001;
      if (hit(`CDR_A_HXC_L))
        hxc_reg[7:0] <= reg_wdata;
      else if (hit(`CDR_A_HXC_H))
        hxc_reg[15:8] <= reg_wdata;
      else if (host_dma_xfer && host_dma_active)
        hxc_reg <= hxc_reg - 16'h0001;
      if (hx_tc || xtc_end)
        xfer_reg[`CDR_XF_HDMA] <= 1'b0;
      else if (hit(`CDR_A_XFER))
        xfer_reg <= reg_wdata & 8'h7f;
    end
  end

  // Buffer address output, one cycle after the access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buffer_address_bus  <= '0;
      buffer_write_strobe <= 1'b0;
    end else begin
      buffer_write_strobe <= drv_ok;
      if (host_dma_xfer && host_dma_active)
        buffer_address_bus <= hac_reg;
      else if (drv_ok || cpu_dma_byte)
        buffer_address_bus <= dac_reg;
    end
  end

  // Sync spacing and decoder timeout
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_cnt  <= '0;
      tout_cnt <= '0;
      mode_q   <= cdr_pkg::CDR_IDLE;
    end else begin
      mode_q <= mode;
      if (sync_ev)
        gap_cnt <= '0;
      else if (drv_ok && gap_cnt != 12'hfff)
        gap_cnt <= gap_cnt + 12'd1;
      if (!tout_mode || sync_ev)
        tout_cnt <= '0;
      else if (mode != mode_q)
        tout_cnt <= 23'(TOUT_CYC);
      else if (tout_cnt != '0)
        tout_cnt <= tout_cnt - 23'd1;
    end
  end

  // Host interrupt flags and busy; set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_interrupt_state <= '0;
      host_busy_flag <= 1'b0;
    end else if (init_busy) begin
      host_interrupt_state <= '0;
      host_busy_flag <= 1'b0;
    end else begin
      host_interrupt_state <= (host_interrupt_state & ~host_ev.clr_int)
                            | (hit(`CDR_A_HIF) ? reg_wdata[2:0] : 3'h0);
      if (host_ev.cmd_wr)
        host_busy_flag <= 1'b1;
      else if (hit(`CDR_A_HIF) && reg_wdata[`CDR_HIF_CLRB])
        host_busy_flag <= 1'b0;
    end
  end

  // Result FIFO
  always_ff @(posedge clk) begin
    if (wr_hit)
      fifo[wp] <= reg_wdata;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
      result_data <= '0;
    end else if (init_busy || (hit(`CDR_A_HIF) && reg_wdata[`CDR_HIF_CLRR])) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (wr_hit)
        wp <= (wp == PW'(DEPTH - 1)) ? '0 : wp + PW'(1);
      if (rd_ok) begin
        rp <= (rp == PW'(DEPTH - 1)) ? '0 : rp + PW'(1);
        result_data <= fifo[rp];
      end
      cnt <= cnt + (PW+1)'(wr_hit) - (PW+1)'(rd_ok);
    end
  end

  // Register read port, data one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `CDR_A_STS:    reg_rdata <= {1'b0, sts_reg};
        `CDR_A_HOST_INTERFACE_STATE: reg_rdata <= {host_busy_flag, result_fifo_empty,
                                     cnt != (PW+1)'(DEPTH), 2'b00, host_interrupt_state};
        `CDR_A_CHIP:   reg_rdata <= chip_reg | {6'h00, init_busy, 1'b0};
        `CDR_A_PAGE:   reg_rdata <= page_reg;
        `CDR_A_DLA_L:  reg_rdata <= dla_reg[7:0];
        `CDR_A_DLA_H:  reg_rdata <= dla_reg[15:8];
        `CDR_A_DAC_L:  reg_rdata <= dac_reg[7:0];
        `CDR_A_DAC_H:  reg_rdata <= dac_reg[15:8];
        `CDR_A_HAC_L:  reg_rdata <= hac_reg[7:0];
        `CDR_A_HAC_H:  reg_rdata <= hac_reg[15:8];
        `CDR_A_HXC_L:  reg_rdata <= hxc_reg[7:0];
        `CDR_A_HXC_H:  reg_rdata <= hxc_reg[15:8];
        `CDR_A_XFER:   reg_rdata <= xfer_reg;
        `CDR_A_DEC:    reg_rdata <= dec_reg;
        default:       reg_rdata <= 8'h00;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_irq_from_status: assert property (|(sts_reg & mask_reg) |-> irq)
    else $error("irq low with enabled status");
  a_irq_masked: assert property (!(|(sts_reg & mask_reg)) |-> !irq)
    else $error("irq high with no enabled status");
  a_clear_status: assert property (hit(`CDR_A_CLR) && reg_wdata[0] && !sts_set[0] && !init_busy
                                   |=> !sts_reg[0])
    else $error("status not cleared");
  a_set_wins: assert property (sts_set[3] |=> sts_reg[3])
    else $error("command status lost");
  a_tc_stops_dma: assert property (hx_tc && !init_busy |=> !host_dma_active && sts_reg[1])
    else $error("transfer count did not stop dma");
  a_stop_blocks: assert property (drv_ok && dac_reg == dla_reg && stop_mode && dec_reg[7]
                                  && !hit(`CDR_A_DEC) |=> drive_write_blocked[*2])
    else $error("drive writes not blocked");
  a_soft_reset_end: assert property ($rose(init_busy) && !init_host |-> ##4 !init_busy)
    else $error("soft reset did not finish");
  a_host_reset_flag: assert property ($rose(init_busy) && host_ev.chip_reset == 1'b0 && init_host
                                      |-> ##[1:5] sts_reg[4])
    else $error("host reset not flagged");
  a_fifo_bound: assert property (cnt <= (PW+1)'(DEPTH))
    else $error("result fifo overfilled");
  a_host_interrupt_flag_hold: assert property (host_interrupt_state[0] && !host_ev.clr_int[0] && !init_busy
                                |=> host_interrupt_state[0])
    else $error("host flag dropped");
  a_drained: assert property (rd_ok && cnt == (PW+1)'(1) && !wr_hit |=> sts_reg[5] && result_fifo_empty)
    else $error("drained status missing");

  c_timeout: cover property (sts_set[6]);
  c_overrun: cover property (sts_set[2] && mode == cdr_pkg::CDR_AUDIO);
  c_fifo_full: cover property (cnt == (PW+1)'(DEPTH));
  c_xtc_end: cover property (xtc_end);
endmodule

// ---- verification/cdr_cpu_model.sv ----
// Register-port master standing in for the local control processor.
// Assumes the bench calls its tasks; every change follows a rising edge.
`timescale 1ns/1ns
`include "cdr_ctl_regs.svh"
module cdr_cpu_model (
  input  wire logic       clk,
  output logic      [3:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr  = 4'h0;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // Counters loaded low byte first, then the high byte at the next offset
  task automatic load16(input logic [3:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 4'h1, v[15:8]);
  endtask
  // Host flag raised only after its state reads low
  task automatic set_host_interrupt_flag(input int n);
    logic [7:0] s;
    rd(`CDR_A_HOST_INTERFACE_STATE, s);
    if (s[n] === 1'b0) wr(`CDR_A_HIF, 8'h01 << n);
  endtask
endmodule

// ---- verification/cdr_ctl_bench.sv ----
// Self-checking bench for the decoder control register bank.
// Assumes the processor model drives the register port.
`timescale 1ns/1ns
`include "cdr_ctl_regs.svh"
module cdr_ctl_bench;
  localparam int TOUT = 50;
  logic                  clk, rst_n, reg_wr, reg_rd, irq, cpu_dma_byte, host_dma_xfer;
  logic                  external_terminal_count, buffer_write_strobe, drive_write_blocked;
  logic                  host_dma_active, sync_window_open, repeat_correction_go, init_busy;
  logic                  host_busy_flag, result_fifo_empty;
  logic [3:0]            reg_addr;
  logic [7:0]            reg_wdata, reg_rdata, result_data;
  logic [15:0]           buffer_address_bus;
  logic [2:0]            host_interrupt_state;
  cdr_pkg::cdr_drive_ev_s drive_ev;
  cdr_pkg::cdr_host_ev_s  host_ev;
  int                    n_mismatch, tests_run, n_strobe, n_go;

  cdr_ctl #(.TOUT_CYC(TOUT), .DEPTH(10)) u_cdr_ctl (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .drive_ev(drive_ev),
    .cpu_dma_byte(cpu_dma_byte), .host_dma_xfer(host_dma_xfer),
    .external_terminal_count(external_terminal_count), .host_ev(host_ev), .irq(irq),
    .buffer_address_bus(buffer_address_bus), .buffer_write_strobe(buffer_write_strobe),
    .drive_write_blocked(drive_write_blocked), .host_dma_active(host_dma_active),
    .sync_window_open(sync_window_open), .repeat_correction_go(repeat_correction_go),
    .init_busy(init_busy), .host_interrupt_state(host_interrupt_state),
    .host_busy_flag(host_busy_flag), .result_data(result_data),
    .result_fifo_empty(result_fifo_empty));
  cdr_cpu_model u_cdr_cpu_model (
    .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (buffer_write_strobe === 1'b1) n_strobe++;
    if (repeat_correction_go === 1'b1) n_go++;
  end

  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk_v(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t value %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_b(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t flag %b expected %b", $time, g, e);
    end
  endtask
  task automatic rdv(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    u_cdr_cpu_model.rd(a, d);
    chk_v({8'h00, d & m}, {8'h00, e});
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    u_cdr_cpu_model.wr(a, d);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One-cycle pulse on host events, drive events and {cpu dma, host xfer, tc}
  task automatic pulse(input logic [5:0] h, input logic [3:0] d, input logic [2:0] o);
    @(posedge clk);
    host_ev <= h;
    drive_ev <= d;
    {cpu_dma_byte, host_dma_xfer, external_terminal_count} <= o;
    @(posedge clk);
    host_ev <= 6'h00;
    drive_ev <= 4'h0;
    {cpu_dma_byte, host_dma_xfer, external_terminal_count} <= 3'h0;
  endtask

  task automatic t_irq;
    pulse(6'h20, 4'h0, 3'h0);
    rdv(`CDR_A_STS, 8'h08, 8'h08);
    chk_b(irq, 1'b0);
    wr(`CDR_A_MASK, 8'h08);
    tick(1);
    chk_b(irq, 1'b1);
    wr(`CDR_A_CLR, 8'h08);
    tick(1);
    chk_b(irq, 1'b0);
    pulse(6'h20, 4'h0, 3'h0);
    rdv(`CDR_A_STS, 8'h08, 8'h08);
    wr(`CDR_A_CLR, 8'h7f);
    wr(`CDR_A_MASK, 8'h00);
  endtask
  task automatic t_hdma;
    u_cdr_cpu_model.load16(`CDR_A_HAC_L, 16'h1230);
    u_cdr_cpu_model.load16(`CDR_A_HXC_L, 16'h0002);
    wr(`CDR_A_XFER, 8'h0a);
    repeat (2) pulse(6'h00, 4'h0, 3'h2);
    tick(1);
    chk_b(host_dma_active, 1'b0);
    chk_v(buffer_address_bus, 16'h1231);
    rdv(`CDR_A_STS, 8'h02, 8'h02);
    rdv(`CDR_A_HXC_L, 8'hff, 8'h00);
    pulse(6'h00, 4'h0, 3'h2);
    rdv(`CDR_A_HAC_L, 8'hff, 8'h32);
    wr(`CDR_A_CLR, 8'h02);
    wr(`CDR_A_XFER, 8'h06);
    pulse(6'h00, 4'h0, 3'h1);
    tick(1);
    chk_b(host_dma_active, 1'b0);
    rdv(`CDR_A_STS, 8'h02, 8'h02);
  endtask
  task automatic t_ovr;
    wr(`CDR_A_CLR, 8'h7f);
    u_cdr_cpu_model.load16(`CDR_A_DLA_L, 16'h0002);
    u_cdr_cpu_model.load16(`CDR_A_DAC_L, 16'h0000);
    wr(`CDR_A_DEC, 8'h82);
    repeat (4) pulse(6'h00, 4'h1, 3'h0);
    tick(1);
    chk_v(16'(n_strobe), 16'h0003);
    chk_b(drive_write_blocked, 1'b1);
    chk_v(buffer_address_bus, 16'h0002);
    rdv(`CDR_A_STS, 8'h04, 8'h04);
    rdv(`CDR_A_DAC_L, 8'hff, 8'h03);
    wr(`CDR_A_CLR, 8'h04);
    wr(`CDR_A_DEC, 8'h05);
    u_cdr_cpu_model.load16(`CDR_A_DLA_L, 16'h0004);
    repeat (2) pulse(6'h00, 4'h1, 3'h0);
    rdv(`CDR_A_STS, 8'h04, 8'h04);
    chk_b(drive_write_blocked, 1'b0);
  endtask
  task automatic t_sync;
    wr(`CDR_A_DEC, 8'h00);
    wr(`CDR_A_CLR, 8'h7f);
    wr(`CDR_A_DEC, 8'h01);
    rdv(`CDR_A_STS, 8'h40, 8'h00);
    tick(TOUT + 10);
    rdv(`CDR_A_STS, 8'h40, 8'h40);
    pulse(6'h00, 4'h8, 3'h0);
    rdv(`CDR_A_STS, 8'h01, 8'h01);
    wr(`CDR_A_CHIP, 8'h04);
    tick(1);
    chk_b(sync_window_open, 1'b1);
    wr(`CDR_A_CLR, 8'h01);
    pulse(6'h00, 4'h8, 3'h0);
    rdv(`CDR_A_STS, 8'h01, 8'h00);
    wr(`CDR_A_CHIP, 8'h00);
  endtask
  task automatic t_rep;
    wr(`CDR_A_CLR, 8'h7f);
    wr(`CDR_A_DEC, 8'h04);
    wr(`CDR_A_CHIP, 8'h08);
    tick(3);
    chk_v(16'(n_go), 16'h0001);
    rdv(`CDR_A_CHIP, 8'h08, 8'h00);
    pulse(6'h00, 4'h2, 3'h0);
    rdv(`CDR_A_STS, 8'h01, 8'h01);
    wr(`CDR_A_DEC, 8'h00);
    u_cdr_cpu_model.load16(`CDR_A_DAC_L, 16'h0100);
    pulse(6'h00, 4'h0, 3'h4);
    tick(1);
    chk_v(buffer_address_bus, 16'h0100);
    rdv(`CDR_A_DAC_L, 8'hff, 8'h01);
  endtask
  task automatic t_hif;
    u_cdr_cpu_model.set_host_interrupt_flag(0);
    wr(`CDR_A_HIF, 8'h00);
    tick(1);
    chk_v({13'h0, host_interrupt_state}, 16'h0001);
    pulse(6'h01, 4'h0, 3'h0);
    tick(1);
    chk_v({13'h0, host_interrupt_state}, 16'h0000);
    chk_b(host_busy_flag, 1'b1);
    wr(`CDR_A_HIF, 8'h80);
    tick(1);
    chk_b(host_busy_flag, 1'b0);
    wr(`CDR_A_CLR, 8'h7f);
    for (int i = 0; i < 11; i++) wr(`CDR_A_RSLT, 8'h10 + 8'(i));
    rdv(`CDR_A_HOST_INTERFACE_STATE, 8'h20, 8'h00);
    for (int i = 0; i < 10; i++) begin
      if (i == 9) rdv(`CDR_A_STS, 8'h20, 8'h00);
      pulse(6'h08, 4'h0, 3'h0);
      tick(0);
      chk_v({8'h00, result_data}, 16'h0010 + 16'(i));
    end
    chk_b(result_fifo_empty, 1'b1);
    rdv(`CDR_A_STS, 8'h20, 8'h20);
    wr(`CDR_A_RSLT, 8'h55);
    tick(1);
    chk_b(result_fifo_empty, 1'b0);
    wr(`CDR_A_HIF, 8'h40);
    tick(1);
    chk_b(result_fifo_empty, 1'b1);
  endtask
  task automatic t_rst;
    wr(`CDR_A_MASK, 8'h10);
    wr(`CDR_A_CHIP, 8'h02);
    tick(0);
    chk_b(init_busy, 1'b1);
    rdv(`CDR_A_CHIP, 8'h02, 8'h02);
    tick(6);
    chk_b(init_busy, 1'b0);
    rdv(`CDR_A_CHIP, 8'h02, 8'h00);
    rdv(`CDR_A_STS, 8'h7f, 8'h00);
    pulse(6'h10, 4'h0, 3'h0);
    tick(6);
    rdv(`CDR_A_STS, 8'h10, 8'h10);
    chk_b(irq, 1'b1);
  endtask

  initial begin
    rst_n = 1'b0;
    host_ev = 6'h00;
    drive_ev = 4'h0;
    {cpu_dma_byte, host_dma_xfer, external_terminal_count} = 3'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_irq();
    t_hdma();
    t_ovr();
    t_sync();
    t_rep();
    t_hif();
    t_rst();
    give_verdict();
  end
  initial begin
    #500000;
    n_mismatch++;
    give_verdict();
  end
endmodule
